// ===== testbench/cooc_host_model.sv
// host model: byte write and byte read commands toward the control block
`timescale 1ns/10ps
module cooc_host_model (
    // clock
    input  wire logic       clk,
    // command port
    output logic            cmdWrite,
    output logic            cmdRead,
    output logic [7:0]      cmdCode,
    output logic [7:0]      cmdData,
    // answer
    input  wire logic [7:0] readData,
    input  wire logic       readValid
);
    initial begin
        cmdWrite = 1'b0;
        cmdRead  = 1'b0;
        cmdCode  = 8'hFF;
        cmdData  = 8'hFF;
    end

    // ----------------------------------------
    // byte transfers
    // ----------------------------------------
    // released lines show the inverse of the last value
    task automatic writeByte(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk);
        cmdWrite <= 1'b1;
        cmdCode  <= code;
        cmdData  <= data;
        @(posedge clk);
        cmdWrite <= 1'b0;
        cmdCode  <= ~code;
        cmdData  <= ~data;
    endtask

    task automatic readByte(input logic [7:0] code, output logic [7:0] data,
                            output logic ok);
        @(posedge clk);
        cmdRead <= 1'b1;
        cmdCode <= code;
        @(posedge clk);
        cmdRead <= 1'b0;
        cmdCode <= ~code;
        #1;
        data = readData;
        ok   = readValid;
    endtask
endmodule

// ===== testbench/testbench.sv
// testbench: run-control and start-condition register checks
`timescale 1ns/10ps
module testbench;
    import cooc_pkg::*;
    logic clk, rst, clkEn, clearInvalid, invalidDataFlag, alertOut;
    logic cmdWrite, cmdRead, readValid;
    logic [7:0] cmdCode, cmdData, readData, startCfgInit;
    logic enableUndervoltPin, inputPowerOk, otherPrereqOk, outputAtZero;
    logic ovFault, uvFault, convertOn, stageHighZ, rampDown;
    logic pinLockoutEn, faultActEn, faultOut;
    cooc_target_type targetSel;
    logic [2:0] obs;
    logic [3:0] codes [7];
    logic [7:0] v;
    logic ign;
    int errCount, testsRun;
    assign obs = {rampDown, stageHighZ, convertOn};

    cooc_on_off_ctrl #(.HOLD_COUNT(4), .RAMP_COUNT(4)) cooc_on_off_ctrl_i (
        .clk(clk), .rst(rst), .clkEn(clkEn), .cmdWrite(cmdWrite),
        .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdData(cmdData),
        .readData(readData), .readValid(readValid),
        .clearInvalid(clearInvalid), .invalidDataFlag(invalidDataFlag),
        .alertOut(alertOut), .enableUndervoltPin(enableUndervoltPin),
        .inputPowerOk(inputPowerOk), .otherPrereqOk(otherPrereqOk),
        .outputAtZero(outputAtZero), .startCfgInit(startCfgInit),
        .ovFault(ovFault), .uvFault(uvFault), .convertOn(convertOn),
        .stageHighZ(stageHighZ), .rampDown(rampDown), .targetSel(targetSel),
        .pinLockoutEn(pinLockoutEn), .faultActEn(faultActEn),
        .faultOut(faultOut));

    cooc_host_model cooc_host_model_i (
        .clk(clk), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
        .cmdCode(cmdCode), .cmdData(cmdData), .readData(readData),
        .readValid(readValid));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] exp,
                         input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic readChk(input logic [7:0] code, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        cooc_host_model_i.readByte(code, d, ok);
        check("readValid", 8'h01, {7'h00, ok});
        check("readData", exp, d);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // bounded wait for one power-stage output: 0 run, 1 high-Z, 2 ramp
    task automatic waitObs(input string name, input int sel, input logic val,
                           input int lim);
        int n;
        n = 0;
        #1;
        while (obs[sel] !== val && n < lim) begin
            settle(1);
            n++;
        end
        check(name, {7'h00, val}, {7'h00, obs[sel]});
    endtask

    // invalid write: old value kept, flag and alert set, then cleared
    task automatic badWrite(input logic [7:0] code, input logic [7:0] data,
                            input logic [7:0] keep);
        cooc_host_model_i.writeByte(code, data);
        settle(2);
        check("invalidDataFlag", 8'h01, {7'h00, invalidDataFlag});
        check("alertOut", 8'h01, {7'h00, alertOut});
        readChk(code, keep);
        @(posedge clk);
        clearInvalid <= 1'b1;
        @(posedge clk);
        clearInvalid <= 1'b0;
        settle(2);
        check("invalidDataFlag", 8'h00, {7'h00, invalidDataFlag});
    endtask

    task automatic endSim;
        if (errCount == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (6000) @(posedge clk);
        errCount++;
        endSim;
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        errCount = 0;
        testsRun = 0;
        rst = 1'b1;
        clkEn = 1'b1;
        clearInvalid = 1'b0;
        enableUndervoltPin = 1'b0;
        inputPowerOk = 1'b1;
        otherPrereqOk = 1'b1;
        outputAtZero = 1'b0;
        startCfgInit = 8'h1A;
        ovFault = 1'b1;
        uvFault = 1'b0;
        codes = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(3);
        check("convertOn", 8'h00, {7'h00, convertOn});
        check("stageHighZ", 8'h01, {7'h00, stageHighZ});
        readChk(CMD_RUN_CONTROL, 8'h00);
        readChk(CMD_START_CONFIG, 8'h1A);
        // every margin code with the enable bit clear and set
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 7; i++) begin
                v = {e[0], 1'b0, codes[i], 2'b00};
                ign = e == 1 && (codes[i] == 4'h5 || codes[i] == 4'h9);
                ovFault <= i[0];
                uvFault <= i[1];
                cooc_host_model_i.writeByte(CMD_RUN_CONTROL, v);
                settle(3);
                check("targetSel", (codes[i] < 4'h3) ? 8'h00 :
                      (codes[i] < 4'h7) ? 8'h01 : 8'h02,
                      {6'h00, targetSel});
                check("faultActEn", {7'h00, !ign},
                      {7'h00, faultActEn});
                check("faultOut", {7'h00, !ign && (i[0] || i[1])},
                      {7'h00, faultOut});
                check("convertOn", {7'h00, e[0]}, {7'h00, convertOn});
                readChk(CMD_RUN_CONTROL, v);
            end
        end
        badWrite(CMD_RUN_CONTROL, 8'h81, 8'hA8);
        badWrite(CMD_RUN_CONTROL, 8'h8C, 8'hA8);
        badWrite(CMD_START_CONFIG, 8'h3A, 8'h1A);
        // soft stop by command
        cooc_host_model_i.writeByte(CMD_RUN_CONTROL, 8'hC0);
        cooc_host_model_i.writeByte(CMD_RUN_CONTROL, 8'h40);
        settle(2);
        check("convertOn", 8'h01, {7'h00, convertOn});
        check("rampDown", 8'h00, {7'h00, rampDown});
        waitObs("rampDown", 2, 1'b1, 12);
        check("convertOn", 8'h01, {7'h00, convertOn});
        outputAtZero <= 1'b1;
        waitObs("convertOn", 0, 1'b0, 6);
        outputAtZero <= 1'b0;
        // profile set then cleared while enabled: immediate stop
        cooc_host_model_i.writeByte(CMD_RUN_CONTROL, 8'h80);
        waitObs("convertOn", 0, 1'b1, 6);
        cooc_host_model_i.writeByte(CMD_RUN_CONTROL, 8'hC0);
        settle(3);
        check("convertOn", 8'h01, {7'h00, convertOn});
        cooc_host_model_i.writeByte(CMD_RUN_CONTROL, 8'h80);
        cooc_host_model_i.writeByte(CMD_RUN_CONTROL, 8'h00);
        waitObs("convertOn", 0, 1'b0, 4);
        check("stageHighZ", 8'h01, {7'h00, stageHighZ});
        check("rampDown", 8'h00, {7'h00, rampDown});
        // pin control, active high, soft then immediate stop
        cooc_host_model_i.writeByte(CMD_START_CONFIG, 8'h16);
        settle(3);
        check("pinLockoutEn", 8'h01, {7'h00, pinLockoutEn});
        enableUndervoltPin <= 1'b1;
        waitObs("convertOn", 0, 1'b1, 8);
        enableUndervoltPin <= 1'b0;
        waitObs("rampDown", 2, 1'b1, 14);
        outputAtZero <= 1'b1;
        waitObs("convertOn", 0, 1'b0, 6);
        outputAtZero <= 1'b0;
        cooc_host_model_i.writeByte(CMD_START_CONFIG, 8'h17);
        enableUndervoltPin <= 1'b1;
        waitObs("convertOn", 0, 1'b1, 8);
        enableUndervoltPin <= 1'b0;
        waitObs("convertOn", 0, 1'b0, 6);
        check("rampDown", 8'h00, {7'h00, rampDown});
        // active low pin
        cooc_host_model_i.writeByte(CMD_START_CONFIG, 8'h15);
        waitObs("convertOn", 0, 1'b1, 8);
        check("pinLockoutEn", 8'h00, {7'h00, pinLockoutEn});
        enableUndervoltPin <= 1'b1;
        waitObs("convertOn", 0, 1'b0, 8);
        // always on with input power, other prerequisites still gate
        cooc_host_model_i.writeByte(CMD_START_CONFIG, 8'h00);
        waitObs("convertOn", 0, 1'b1, 6);
        otherPrereqOk <= 1'b0;
        waitObs("convertOn", 0, 1'b0, 6);
        otherPrereqOk <= 1'b1;
        waitObs("convertOn", 0, 1'b1, 6);
        inputPowerOk <= 1'b0;
        waitObs("convertOn", 0, 1'b0, 6);
        endSim;
    end
endmodule

// ===== verilog/cooc_on_off_ctrl.sv
// module: converter on/off and margin target control
`timescale 1ns/10ps
// Notes on behaviour
// [R1] with command control, enable bit 0 stops and 1 starts conversion
// [R2] start only when all other prerequisites are also met
// [R3] profile bit 0 on off command: stop now, stage high impedance
// [R4] profile bit 1: hold, ramp down, stop at zero volts
// [R5] profile applies only on enable falling under command control
// [R6] margin codes 0,1,2 regulate nominal, faults act normally
// [R7] code 5 low target, faults ignored while enable bit set
// [R8] code 6 low target, faults act normally
// [R9] code 9 high target, faults ignored while enable bit set
// [R10] code 10 high target, faults act normally
// [R11] run bits 1:0 and config bits 7:5 read as zero
// [R12] unlisted run-control write is invalid data, flagged
// [R13] config bit 4 clear: convert whenever input power present
// [R14] config bit 3 selects obeying the run-control command
// [R15] config bit 2 selects obeying the pin; clear disables pin lockout
// [R16] config bit 1 is pin polarity, 1 active high
// [R17] pin off: bit 0 clear soft stop, set immediate stop
// [R18] the enable/undervolt pin is the control pin
// [R19] unlisted start-config write is invalid data, flagged
// [R20] start config at 02h, byte access, nonvolatile, immediate
// [R21] run control at 01h, byte access, volatile, immediate
// [R22] invalid write keeps old value, sets flag, raises alert
module cooc_on_off_ctrl #(
    parameter int HOLD_COUNT = cooc_pkg::HOLD_CYCLES,
    parameter int RAMP_COUNT = cooc_pkg::RAMP_CYCLES
) (
    // clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      clkEn,
    // byte command port from the bus engine
    input  wire logic                      cmdWrite,
    input  wire logic                      cmdRead,
    input  wire logic [7:0]                cmdCode,
    input  wire logic [7:0]                cmdData,
    output logic [7:0]                     readData,
    output logic                           readValid,
    // status toward host
    input  wire logic                      clearInvalid,
    output logic                           invalidDataFlag,
    output logic                           alertOut,
    // analog side
    input  wire logic                      enableUndervoltPin,
    input  wire logic                      inputPowerOk,
    input  wire logic                      otherPrereqOk,
    input  wire logic                      outputAtZero,
    input  wire logic [7:0]                startCfgInit,
    input  wire logic                      ovFault,
    input  wire logic                      uvFault,
    output logic                           convertOn,
    output logic                           stageHighZ,
    output logic                           rampDown,
    output cooc_pkg::cooc_target_type      targetSel,
    output logic                           pinLockoutEn,
    output logic                           faultActEn,
    output logic                           faultOut
);
    import cooc_pkg::*;

    // ------------------------------------------------------------
    // register store
    // ------------------------------------------------------------
    cooc_regs_if regs ();
    logic validWrite;
    logic runValid;
    logic cfgValid;

    assign runValid = (cmdData[1:0] == 2'h0) && (
        cmdData[5:2] == MARGIN_OFF_A || cmdData[5:2] == MARGIN_OFF_B ||
        cmdData[5:2] == MARGIN_OFF_C || cmdData[5:2] == MARGIN_LOW_IG ||
        cmdData[5:2] == MARGIN_LOW_AF || cmdData[5:2] == MARGIN_HI_IG ||
        cmdData[5:2] == MARGIN_HI_AF); // [R12]
    assign cfgValid = (cmdData & START_CFG_RO_MSK) == 8'h00; // [R19]
    assign validWrite = (cmdCode == CMD_RUN_CONTROL && runValid) ||
                        (cmdCode == CMD_START_CONFIG && cfgValid);
    assign regs.wrEn   = cmdWrite && validWrite; // [R22]
    assign regs.wrCode = cmdCode;
    assign regs.wrData = cmdData;

    cooc_reg_store u_store (
        .clk          (clk),
        .rst          (rst),
        .clkEn        (clkEn),
        .startCfgInit (startCfgInit),
        .regs         (regs)
    );

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    logic pinMeta_q;
    logic pinSync_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
        end else if (clkEn) begin
            pinMeta_q <= enableUndervoltPin;
            pinSync_q <= pinMeta_q;
        end
    end

    // ------------------------------------------------------------
    // start-up guard
    // ------------------------------------------------------------
    // no start until the stored config and the pin sampler are valid
    logic [1:0] warm_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            warm_q <= 2'h0;
        end else if (clkEn) begin
            warm_q <= {warm_q[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // on/off decision
    // ------------------------------------------------------------
    logic [7:0] run;
    logic [7:0] cfg;
    logic       pinAsserted;
    logic       cmdOn;
    logic       pinOn;
    logic       wantOn;
    logic       cmdEnable_q;
    logic       cmdFell;
    logic       softOff;
    assign run = regs.runControl;
    assign cfg = regs.startConfig;
    // [R16] [R18]
    assign pinAsserted = cfg[CFG_POLARITY_BIT] ? pinSync_q : ~pinSync_q;
    assign cmdOn = ~cfg[CFG_CMD_BIT] | run[RUN_ENABLE_BIT]; // [R1] [R14]
    assign pinOn = ~cfg[CFG_PIN_BIT] | pinAsserted; // [R15]
    // [R13] [R2]
    assign wantOn = warm_q[1] && inputPowerOk && otherPrereqOk &&
                    (~cfg[CFG_POWER_UP_BIT] || (cmdOn && pinOn));
    assign cmdFell = cmdEnable_q & ~run[RUN_ENABLE_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdEnable_q <= 1'b0;
        end else if (clkEn) begin
            cmdEnable_q <= run[RUN_ENABLE_BIT];
        end
    end

    // soft path: command fall uses profile bit, pin off uses pin-fast bit 0
    always_comb begin
        softOff = 1'b0;
        if (cfg[CFG_POWER_UP_BIT] && inputPowerOk && otherPrereqOk) begin
            if (cfg[CFG_CMD_BIT] && cmdFell) begin
                softOff = run[RUN_PROFILE_BIT]; // [R5]
            end else if (cfg[CFG_PIN_BIT] && !pinAsserted) begin
                softOff = ~cfg[CFG_PIN_FAST_BIT]; // [R17]
            end
        end
    end

    // ------------------------------------------------------------
    // conversion state machine
    // ------------------------------------------------------------
    cooc_state_type state_q;
    logic [31:0]    timer_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_OFF;
            timer_q <= 32'h0;
        end else if (clkEn) begin
            unique case (state_q)
                ST_OFF: begin
                    if (wantOn) begin
                        state_q <= ST_ON;
                    end
                end
                ST_ON: begin
                    if (!wantOn) begin
                        if (softOff) begin
                            state_q <= ST_HOLD; // [R4]
                            timer_q <= 32'h0;
                        end else begin
                            state_q <= ST_OFF; // [R3]
                        end
                    end
                end
                ST_HOLD: begin
                    if (timer_q >= 32'(HOLD_COUNT - 1)) begin
                        state_q <= ST_RAMP; // [R4]
                        timer_q <= 32'h0;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                ST_RAMP: begin
                    if (outputAtZero) begin
                        state_q <= ST_OFF; // [R4]
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registered outputs toward the power stage
    // ------------------------------------------------------------
    logic [3:0] margin;
    logic       ignoreFaults;
    assign margin = run[RUN_MARGIN_HI:RUN_MARGIN_LO];
    // [R7] [R9]
    assign ignoreFaults = run[RUN_ENABLE_BIT] &&
        (margin == MARGIN_LOW_IG || margin == MARGIN_HI_IG);

    always_ff @(posedge clk) begin
        if (rst) begin
            convertOn    <= 1'b0;
            stageHighZ   <= 1'b1;
            rampDown     <= 1'b0;
            targetSel    <= TGT_NOMINAL;
            pinLockoutEn <= 1'b0;
            faultActEn   <= 1'b1;
            faultOut     <= 1'b0;
        end else if (clkEn) begin
            convertOn  <= state_q != ST_OFF;
            stageHighZ <= state_q == ST_OFF; // [R3]
            rampDown   <= state_q == ST_RAMP; // [R4]
            if (margin == MARGIN_LOW_IG || margin == MARGIN_LOW_AF) begin
                targetSel <= TGT_LOW; // [R7] [R8]
            end else if (margin == MARGIN_HI_IG ||
                         margin == MARGIN_HI_AF) begin
                targetSel <= TGT_HIGH; // [R9] [R10]
            end else begin
                targetSel <= TGT_NOMINAL; // [R6]
            end
            // [R15] [R16]
            pinLockoutEn <= cfg[CFG_PIN_BIT] & cfg[CFG_POLARITY_BIT];
            faultActEn   <= ~ignoreFaults; // [R6] [R8] [R10]
            faultOut     <= ~ignoreFaults & (ovFault | uvFault);
        end
    end

    // ------------------------------------------------------------
    // read path and invalid-data status
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            readData  <= 8'h00;
            readValid <= 1'b0;
        end else if (clkEn) begin
            readValid <= cmdRead;
            if (cmdRead) begin
                if (cmdCode == CMD_RUN_CONTROL) begin
                    readData <= run; // [R21]
                end else if (cmdCode == CMD_START_CONFIG) begin
                    readData <= cfg; // [R20]
                end else begin
                    readData <= 8'h00;
                end
            end
        end
    end

    // set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            invalidDataFlag <= 1'b0;
            alertOut        <= 1'b0;
        end else if (clkEn) begin
            if (cmdWrite && !validWrite &&
                (cmdCode == CMD_RUN_CONTROL ||
                 cmdCode == CMD_START_CONFIG)) begin
                invalidDataFlag <= 1'b1; // [R12] [R19] [R22]
                alertOut        <= 1'b1;
            end else if (clearInvalid) begin
                invalidDataFlag <= 1'b0;
                alertOut        <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    invalid_flag_a: assert property (@(posedge clk) disable iff (rst) // [R22]
        clkEn && cmdWrite && cmdCode == CMD_RUN_CONTROL && !runValid
        |=> invalidDataFlag && alertOut && $stable(regs.runControl))
        else $error("invalid run write not flagged");
    ro_bits_a: assert property (@(posedge clk) disable iff (rst) // [R11]
        regs.runControl[1:0] == 2'h0 && regs.startConfig[7:5] == 3'h0)
        else $error("read-only bits nonzero");
    hard_off_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        clkEn && state_q == ST_ON && !wantOn && !softOff
        |=> state_q == ST_OFF)
        else $error("immediate off not taken");
    soft_hold_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        clkEn && state_q == ST_ON && !wantOn && softOff
        |=> state_q == ST_HOLD)
        else $error("soft off not entered");
    ramp_end_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        clkEn && state_q == ST_RAMP && outputAtZero |=> state_q == ST_OFF)
        else $error("ramp did not stop at zero");
    power_up_a: assert property (@(posedge clk) disable iff (rst) // [R13]
        warm_q[1] && clkEn && state_q == ST_OFF && !cfg[CFG_POWER_UP_BIT] &&
        inputPowerOk && otherPrereqOk |=> state_q == ST_ON)
        else $error("always-on start missed");
    prereq_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        clkEn && state_q == ST_OFF && !otherPrereqOk |=> state_q == ST_OFF)
        else $error("started without prerequisites");
    low_target_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        clkEn && margin == MARGIN_LOW_AF
        |=> targetSel == TGT_LOW && faultActEn)
        else $error("low margin act-on-fault wrong");
    ignore_fault_a: assert property (@(posedge clk) disable iff (rst) // [R9]
        clkEn && margin == MARGIN_HI_IG && run[RUN_ENABLE_BIT]
        |=> !faultActEn && !faultOut)
        else $error("faults not ignored in high margin");
    valid_write_a: assert property (@(posedge clk) disable iff (rst) // [R21]
        clkEn && cmdWrite && cmdCode == CMD_RUN_CONTROL && runValid
        |=> regs.runControl == $past(cmdData))
        else $error("valid run write not applied");
    bad_config_a: assert property (@(posedge clk) disable iff (rst) // [R19]
        warm_q[0] && clkEn && cmdWrite && cmdCode == CMD_START_CONFIG &&
        !cfgValid |=> invalidDataFlag && alertOut &&
        $stable(regs.startConfig))
        else $error("invalid config write not flagged");
    config_read_a: assert property (@(posedge clk) disable iff (rst) // [R20]
        clkEn && cmdRead && cmdCode == CMD_START_CONFIG
        |=> readValid && readData == $past(regs.startConfig))
        else $error("config read back wrong");
    hold_stay_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        clkEn && state_q == ST_HOLD && timer_q < 32'(HOLD_COUNT - 1)
        |=> state_q == ST_HOLD)
        else $error("hold ended early");
    pin_fast_a: assert property (@(posedge clk) disable iff (rst) // [R17]
        clkEn && state_q == ST_ON && !wantOn && !cfg[CFG_CMD_BIT] &&
        cfg[CFG_PIN_FAST_BIT] |=> state_q == ST_OFF)
        else $error("pin immediate stop not taken");
    low_ignore_a: assert property (@(posedge clk) disable iff (rst) // [R7]
        clkEn && margin == MARGIN_LOW_IG && run[RUN_ENABLE_BIT]
        |=> targetSel == TGT_LOW && !faultActEn && !faultOut)
        else $error("faults not ignored in low margin");
    start_guard_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        clkEn && !warm_q[1] |=> state_q == ST_OFF)
        else $error("started before config was valid");
endmodule

// ===== verilog/cooc_pkg.sv
// package: command codes, field positions, reset values, states
package cooc_pkg;
    localparam logic [7:0] CMD_RUN_CONTROL  = 8'h01;
    localparam logic [7:0] CMD_START_CONFIG = 8'h02;
    localparam int RUN_ENABLE_BIT   = 7;
    localparam int RUN_PROFILE_BIT  = 6;
    localparam int RUN_MARGIN_HI    = 5;
    localparam int RUN_MARGIN_LO    = 2;
    localparam int CFG_POWER_UP_BIT = 4;
    localparam int CFG_CMD_BIT      = 3;
    localparam int CFG_PIN_BIT      = 2;
    localparam int CFG_POLARITY_BIT = 1;
    localparam int CFG_PIN_FAST_BIT = 0;
    localparam logic [7:0] RUN_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] RUN_CONTROL_RO_MSK = 8'h03;
    localparam logic [7:0] START_CFG_RO_MSK   = 8'hE0;
    localparam logic [7:0] START_CFG_RESET    = 8'h00;
    localparam logic [3:0] MARGIN_OFF_A  = 4'h0;
    localparam logic [3:0] MARGIN_OFF_B  = 4'h1;
    localparam logic [3:0] MARGIN_OFF_C  = 4'h2;
    localparam logic [3:0] MARGIN_LOW_IG = 4'h5;
    localparam logic [3:0] MARGIN_LOW_AF = 4'h6;
    localparam logic [3:0] MARGIN_HI_IG  = 4'h9;
    localparam logic [3:0] MARGIN_HI_AF  = 4'hA;
    // hold time at 40 MHz; default value chosen, parameter overrides
    localparam int CLK_MHZ          = 40;
    localparam int HOLD_TIME_US     = 1000;
    localparam int HOLD_CYCLES      = HOLD_TIME_US * CLK_MHZ;
    localparam int RAMP_TIME_US     = 1000;
    localparam int RAMP_CYCLES      = RAMP_TIME_US * CLK_MHZ;
    // target selection
    typedef enum logic [1:0] {
        TGT_NOMINAL = 2'h0,
        TGT_LOW     = 2'h1,
        TGT_HIGH    = 2'h2
    } cooc_target_type;
    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,
        ST_ON   = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_RAMP = 4'b1000
    } cooc_state_type;
endpackage

// ===== verilog/cooc_reg_store.sv
// module: the two command registers
`timescale 1ns/10ps
module cooc_reg_store (
    // clock, reset, enable and config image
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      clkEn,
    input  wire logic [7:0] startCfgInit,
    // register path
    cooc_regs_if.owner     regs
);
    import cooc_pkg::*;
    logic [7:0] runControl_q;
    logic [7:0] startConfig_q;
    logic       loadCfg_q;
    assign regs.runControl  = runControl_q;
    assign regs.startConfig = startConfig_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            runControl_q <= RUN_CONTROL_RESET;
        end else if (clkEn && regs.wrEn &&
                     regs.wrCode == CMD_RUN_CONTROL) begin
            runControl_q <= regs.wrData & ~RUN_CONTROL_RO_MSK; // [R11]
        end
    end

    // nonvolatile image is loaded in the first enabled cycle after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            startConfig_q <= START_CFG_RESET;
            loadCfg_q     <= 1'b1;
        end else if (clkEn) begin
            loadCfg_q <= 1'b0;
            if (loadCfg_q) begin
                startConfig_q <= startCfgInit & ~START_CFG_RO_MSK; // [R20]
            end else if (regs.wrEn && regs.wrCode == CMD_START_CONFIG) begin
                startConfig_q <= regs.wrData & ~START_CFG_RO_MSK; // [R11]
            end
        end
    end
endmodule

// ===== verilog/cooc_regs_if.sv
// interface: register store write/read path
`timescale 1ns/10ps
interface cooc_regs_if;
    logic       wrEn;
    logic [7:0] wrCode;
    logic [7:0] wrData;
    logic [7:0] runControl;
    logic [7:0] startConfig;
    modport owner (input wrEn, wrCode, wrData,
                   output runControl, startConfig);
    modport user  (output wrEn, wrCode, wrData,
                   input runControl, startConfig);
endinterface
